// [src/debug_counter_pkg.sv]
`default_nettype none
package debug_counter_pkg;

    localparam int unsigned COUNT_W = 24;
    localparam logic [COUNT_W-1:0] COUNT_RESET = 24'h000000;
    localparam logic [COUNT_W-1:0] COUNT_ONE   = 24'h000001;

    // two-bit debug counter control setting
    typedef enum logic [1:0] {
        CTRL_FREE_RUN   = 2'h0,
        CTRL_FROZEN     = 2'h1,
        CTRL_INIT_ONCE  = 2'h2,
        CTRL_INIT_ALWAYS = 2'h3
    } counter_ctrl_t;

    // front-end operating mode
    typedef enum logic [2:0] {
        MODE_GENERIC                = 3'h0,
        MODE_INVERSE_SCAN           = 3'h1,
        MODE_VARIABLE_LENGTH_DECODE = 3'h2,
        MODE_H264_TRANSFORM         = 3'h3,
        MODE_H264_MOTION_COMP       = 3'h4,
        MODE_WMV9_TRANSFORM         = 3'h5
    } fe_mode_t;

endpackage
`default_nettype wire

// [src/tag_select.sv]
`timescale 1ns/1ps
`default_nettype none
// picks the reload tag source: state tag for transform/motion modes, else command tag
module tag_select (
    // mode and tag sources
    input  wire logic [2:0]                                mode_i,
    input  wire logic [debug_counter_pkg::COUNT_W-1:0]     object_tag_i,
    input  wire logic [debug_counter_pkg::COUNT_W-1:0]     state_tag_i,
    // selection
    output logic                                           primitive_mode_o,
    output logic [debug_counter_pkg::COUNT_W-1:0]          tag_o
);

    always_comb begin
        primitive_mode_o = (mode_i == debug_counter_pkg::MODE_H264_TRANSFORM)
                        || (mode_i == debug_counter_pkg::MODE_H264_MOTION_COMP)
                        || (mode_i == debug_counter_pkg::MODE_WMV9_TRANSFORM);
        tag_o = primitive_mode_o ? state_tag_i : object_tag_i;
    end

endmodule
`default_nettype wire

// [src/media_debug_thread_counter.sv]
// Summary of operation
// RL1: 24-bit counter advances per root thread delivered to the spawner.
// RL2: counter is zero after reset.
// RL3: free-run, generic/inverse-scan: keep value, add one per work item.
// RL4: free-run, decode mode: add one per generated macroblock thread.
// RL5: frozen setting: value never changes on commands.
// RL6: init-once, generic/inverse-scan: load first work item tag after state change.
// RL7: init-once, decode: load tag at first macroblock after state change.
// RL8: always-init, generic/inverse-scan: reload tag on every work item.
// RL9: software never selects always-init in decode mode.
// RL10: free-run in transform/motion modes: add one per primitive command.
// RL11: init-once transform/motion: load state command tag, then count primitives.
// RL12: software never selects always-init in transform/motion modes.
// RL13: counter is not saved or restored across context switches.
// RL14: increment from all ones wraps to zero.
`timescale 1ns/1ps
`default_nettype none
module media_debug_thread_counter (
    // clock and reset
    input  wire logic                                  clk_i,
    input  wire logic                                  reset_n_i,
    // front-end state
    input  wire logic [1:0]                            counter_ctrl_i,
    input  wire logic [2:0]                            fe_mode_i,
    input  wire logic                                  state_change_i,
    input  wire logic [debug_counter_pkg::COUNT_W-1:0] state_tag_i,
    // root thread delivered toward the thread spawner unit
    input  wire logic                                  root_thread_i,
    input  wire logic [debug_counter_pkg::COUNT_W-1:0] primitive_tag_value_i,
    // count out
    output logic [debug_counter_pkg::COUNT_W-1:0]      debug_count_o
);

    // what the next edge does to the count
    typedef enum logic [1:0] {
        ACT_HOLD,
        ACT_STEP,
        ACT_LOAD
    } count_action_t;

    // whether a state change still owes a tag load to the next work item
    typedef enum logic {
        INIT_IDLE,
        INIT_ARMED
    } init_state_t;

    // counter state
    logic [debug_counter_pkg::COUNT_W-1:0] count;
    logic [debug_counter_pkg::COUNT_W-1:0] next_count;
    init_state_t                           init_state;
    init_state_t                           next_init_state;

    // decoded controls and modes
    debug_counter_pkg::counter_ctrl_t      ctrl;
    logic                                  primitive_mode;
    logic                                  decode_mode;
    logic                                  item_mode;

    // datapath and actions
    logic [debug_counter_pkg::COUNT_W-1:0] reload_tag;
    logic [debug_counter_pkg::COUNT_W-1:0] count_plus_one;
    count_action_t                         action;
    logic                                  primitive_reload;
    logic                                  first_item_load;

    // generic and inverse-scan commands each carry one work item
    function automatic logic is_item_mode(input logic [2:0] mode);
        is_item_mode = (mode == debug_counter_pkg::MODE_GENERIC)
                    || (mode == debug_counter_pkg::MODE_INVERSE_SCAN);
    endfunction

    // in decode mode the threads are macroblocks made inside the front end
    function automatic logic is_decode_mode(input logic [2:0] mode);
        is_decode_mode = (mode == debug_counter_pkg::MODE_VARIABLE_LENGTH_DECODE);
    endfunction

    // reload source follows the mode: state tag for primitives, command tag otherwise
    tag_select u_tag_select (
        .mode_i           (fe_mode_i),
        .object_tag_i     (primitive_tag_value_i),
        .state_tag_i      (state_tag_i),
        .primitive_mode_o (primitive_mode),
        .tag_o            (reload_tag)
    );

    // plain level inputs, decoded once for every process below
    assign ctrl        = debug_counter_pkg::counter_ctrl_t'(counter_ctrl_i);
    assign item_mode   = is_item_mode(fe_mode_i);
    assign decode_mode = is_decode_mode(fe_mode_i);

    // RL13: no save/restore
    // no port carries the value out on a context switch, so it serves one context
    always_comb begin
        action = ACT_HOLD;
        case (ctrl)
            debug_counter_pkg::CTRL_FREE_RUN: begin
                if (!root_thread_i) begin
                    action = ACT_HOLD;
                end else if (primitive_mode) begin
                    // RL10: one per primitive
                    action = ACT_STEP;
                end else if (decode_mode) begin
                    // RL4: one per macroblock
                    action = ACT_STEP;
                end else begin
                    // RL3: one per item
                    action = ACT_STEP;
                end
            end
            debug_counter_pkg::CTRL_FROZEN: begin
                // RL5: hold value
                action = ACT_HOLD;
            end
            debug_counter_pkg::CTRL_INIT_ONCE: begin
                if (primitive_mode) begin
                    if (state_change_i) begin
                        // RL11: load state tag
                        action = ACT_LOAD;
                    end else if (root_thread_i) begin
                        // RL11: then count primitives
                        action = ACT_STEP;
                    end
                end else if (root_thread_i) begin
                    if (init_state == INIT_ARMED) begin
                        // RL6: first item loads
                        // RL7: first macroblock loads
                        action = ACT_LOAD;
                    end else begin
                        action = ACT_STEP;
                    end
                end
            end
            default: begin
                if (!root_thread_i) begin
                    action = ACT_HOLD;
                end else if (item_mode) begin
                    // RL8: reload every item
                    action = ACT_LOAD;
                end else begin
                    // RL9: decode reserved
                    // RL12: transform reserved
                    // reserved setting still reloads, so software misuse stays predictable
                    action = ACT_LOAD;
                end
            end
        endcase
    end

    // RL14: wrap at all ones
    // the carry out of the top bit is dropped on purpose
    assign count_plus_one = count + debug_counter_pkg::COUNT_ONE;

    always_comb begin
        next_count = count;
        case (action)
            ACT_STEP: begin
                // RL1: advance per root
                next_count = count_plus_one;
            end
            ACT_LOAD: begin
                next_count = reload_tag;
            end
            default: begin
                next_count = count;
            end
        endcase
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            // RL2: zero at reset
            count <= debug_counter_pkg::COUNT_RESET;
        end else begin
            count <= next_count;
        end
    end

    // the state tag loads at the state change itself, so nothing is owed afterwards
    assign primitive_reload = (ctrl == debug_counter_pkg::CTRL_INIT_ONCE)
                           && primitive_mode
                           && state_change_i;
    assign first_item_load  = (ctrl == debug_counter_pkg::CTRL_INIT_ONCE)
                           && !primitive_mode
                           && (action == ACT_LOAD);

    always_comb begin
        next_init_state = init_state;
        case (init_state)
            INIT_IDLE: begin
                if (state_change_i && !primitive_reload) begin
                    next_init_state = INIT_ARMED;
                end
            end
            INIT_ARMED: begin
                // a first item that meets a new state change stays owed a load
                if (primitive_reload) begin
                    next_init_state = INIT_IDLE;
                end else if (first_item_load && !state_change_i) begin
                    next_init_state = INIT_IDLE;
                end
            end
            default: begin
                next_init_state = INIT_IDLE;
            end
        endcase
    end

    // a reset leaves nothing owed: no load until the next state change
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            init_state <= INIT_IDLE;
        end else begin
            init_state <= next_init_state;
        end
    end

    assign debug_count_o = count;

endmodule
`default_nettype wire

// [bench/cnt_assertions.sv]
`timescale 1ns/1ps
`default_nettype none
module cnt_assertions (
    input wire logic        clk_i,
    input wire logic        reset_n_i,
    input wire logic [1:0]  counter_ctrl_i,
    input wire logic [2:0]  fe_mode_i,
    input wire logic        state_change_i,
    input wire logic [23:0] state_tag_i,
    input wire logic        root_thread_i,
    input wire logic [23:0] primitive_tag_value_i,
    input wire logic [23:0] debug_count_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!reset_n_i);
    sequence s_armed; counter_ctrl_i == 2'h2 && fe_mode_i <= 3'h2 && state_change_i; endsequence
    sequence s_quiet; !root_thread_i && !state_change_i; endsequence
    sequence s_first; counter_ctrl_i == 2'h2 && root_thread_i && !state_change_i; endsequence
    a_reset_zero: assert property ($rose(reset_n_i) |-> debug_count_o == 24'h0)
        else $error("count not zero after reset");
    a_idle_hold: assert property (s_quiet |=> $stable(debug_count_o))
        else $error("count moved without event");
    a_frozen_hold: assert property (counter_ctrl_i == 2'h1 |=> $stable(debug_count_o))
        else $error("frozen count moved");
    a_free_inc: assert property (counter_ctrl_i == 2'h0 && root_thread_i
        |=> debug_count_o == $past(debug_count_o) + 24'h1) else $error("free count not plus one");
    a_always_load: assert property (counter_ctrl_i == 2'h3 && fe_mode_i <= 3'h1 && root_thread_i
        |=> debug_count_o == $past(primitive_tag_value_i)) else $error("tag not reloaded");
    a_first_load: assert property (s_armed ##1 s_quiet ##1 s_first
        |=> debug_count_o == $past(primitive_tag_value_i)) else $error("first tag not loaded");
    a_state_load: assert property (counter_ctrl_i == 2'h2 && fe_mode_i inside {[3'h3:3'h5]}
        && state_change_i && !root_thread_i |=> debug_count_o == $past(state_tag_i))
        else $error("state tag not loaded");
    a_prim_inc: assert property (counter_ctrl_i == 2'h2 && fe_mode_i inside {[3'h3:3'h5]}
        && root_thread_i && !state_change_i
        |=> debug_count_o == $past(debug_count_o) + 24'h1) else $error("primitive not counted");
endmodule
bind media_debug_thread_counter cnt_assertions cnt_assertions_i (.*);
`default_nettype wire

// [bench/cs_model.sv]
`timescale 1ns/1ps
`default_nettype none
module cs_model (
    input  wire logic   clk_i,
    output logic [1:0]  ctrl_o,
    output logic [2:0]  mode_o,
    output logic        pulse_o [2],
    output logic [23:0] tag_o [2]
);
    initial begin
        ctrl_o = 2'h0;
        mode_o = 3'h0;
        pulse_o = '{1'b0, 1'b0};
        tag_o = '{24'h0, 24'h0};
    end
    task automatic setup(input logic [1:0] c, input logic [2:0] m);
        @(posedge clk_i);
        ctrl_o <= (c == 2'h3 && m > 3'h1) ? 2'h1 : c;
        mode_o <= m;
    endtask
    // released tag lines show the inverse, never the old value
    task automatic send(input int k, input logic [23:0] t);
        @(posedge clk_i);
        pulse_o[k] <= 1'b1;
        tag_o[k] <= t;
        @(posedge clk_i);
        pulse_o[k] <= 1'b0;
        tag_o[k] <= ~t;
    endtask
endmodule
`default_nettype wire

// [bench/tb.sv]
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic clk_i = 1'b0;
    logic reset_n_i = 1'b0;
    logic [1:0] c;
    logic [2:0] m;
    logic p [2];
    logic [23:0] t [2];
    logic [23:0] q;
    int mismatches = 0;
    int tests_run = 0;
    cs_model cs_model_i (.clk_i(clk_i), .ctrl_o(c), .mode_o(m), .pulse_o(p), .tag_o(t));
    media_debug_thread_counter media_debug_thread_counter_i (.clk_i(clk_i),
        .reset_n_i(reset_n_i), .counter_ctrl_i(c), .fe_mode_i(m), .state_change_i(p[0]),
        .state_tag_i(t[0]), .root_thread_i(p[1]), .primitive_tag_value_i(t[1]), .debug_count_o(q));
    initial forever #4 clk_i = ~clk_i;
    task automatic chk(input logic [23:0] e);
        #1;
        tests_run++;
        if (q !== e) begin
            mismatches++;
            $display("ERROR %0t count %h expected %h", $time, q, e);
        end
    endtask
    task automatic free_run;
        chk(24'h0);
        cs_model_i.send(1, 24'h7);
        cs_model_i.send(1, 24'h7);
        chk(24'h2);
        cs_model_i.setup(2'h0, 3'h2);
        cs_model_i.send(1, 24'h7);
        chk(24'h3);
        cs_model_i.setup(2'h3, 3'h1);
        cs_model_i.send(1, 24'hFFFFFF);
        chk(24'hFFFFFF);
        cs_model_i.setup(2'h0, 3'h4);
        cs_model_i.send(1, 24'h7);
        chk(24'h0);
    endtask
    task automatic frozen;
        cs_model_i.setup(2'h1, 3'h0);
        cs_model_i.send(0, 24'h5);
        cs_model_i.send(1, 24'h9);
        chk(24'h0);
    endtask
    task automatic init_once;
        cs_model_i.setup(2'h2, 3'h0);
        cs_model_i.send(0, 24'h5);
        cs_model_i.send(1, 24'h100);
        chk(24'h100);
        cs_model_i.send(1, 24'h200);
        chk(24'h101);
        cs_model_i.setup(2'h2, 3'h2);
        cs_model_i.send(0, 24'h0);
        cs_model_i.send(1, 24'h300);
        cs_model_i.send(1, 24'h1);
        chk(24'h301);
        cs_model_i.setup(2'h2, 3'h3);
        cs_model_i.send(0, 24'h400);
        chk(24'h400);
        cs_model_i.send(1, 24'h0);
        chk(24'h401);
    endtask
    // a load is owed before the reset; afterwards nothing may be owed
    task automatic mid_reset;
        cs_model_i.setup(2'h2, 3'h0);
        cs_model_i.send(0, 24'h5);
        @(posedge clk_i);
        reset_n_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        reset_n_i <= 1'b1;
        chk(24'h0);
        cs_model_i.send(1, 24'h55);
        chk(24'h1);
    endtask
    task automatic complete_run;
        $display("mismatches %0d tests_run %0d", mismatches, tests_run);
        if (mismatches == 0 && tests_run > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    // whole sequence needs well under 100 cycles
    initial begin
        #4000;
        mismatches++;
        complete_run();
    end
    initial begin
        repeat (4) @(posedge clk_i);
        reset_n_i <= 1'b1;
        free_run();
        frozen();
        init_once();
        mid_reset();
        complete_run();
    end
endmodule
`default_nettype wire
